// File: design/clock_gen_pkg.sv
/*
  Shared constants, the clock-source switch states and the divider-field decode for the clock generator.
  Assumes nothing of its surroundings; it is imported by the generator and its divider.
*/
package clock_gen_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // divider field layout and reset value
  localparam int CPU_DIV_W = 4;
  localparam int CPU_DIV_SUB_POS = 3;
  localparam logic [CPU_DIV_W-1:0] CPU_DIV_RESET = 4'h3;
  localparam int CPU_TAPS = 6;
  localparam int PERIPH_TAPS = 11;
  localparam int PERIPH_MODULO = 1024;
  localparam int CPU_MODULO = 32;

  ////////////////////////////////////////////////////////////////////////////
  // frequencies and ratios
  localparam int PLL_MULT = 4;
  localparam int SUB_CLOCK_HZ = 32768;
  localparam int WATCH_DIV_DEFAULT = 122;
  localparam int PLL_CNT_W_DEFAULT = 16;

  ////////////////////////////////////////////////////////////////////////////
  // cpu source switch states, gray along main -> sub -> main
  typedef enum logic [1:0] {
    SRC_MAIN = 2'h0,
    SRC_TO_SUB = 2'h1,
    SRC_SUB = 2'h3,
    SRC_TO_MAIN = 2'h2
  } src_state_e;

  // the codes 011x may not be written
  function automatic logic div_prohibited(input logic [CPU_DIV_W-1:0] field);
    div_prohibited = (field[3:1] == 3'h3);
  endfunction : div_prohibited

  // low bits of a count all ones
  function automatic logic low_ones(input logic [15:0] value, input int bits);
    logic [15:0] mask;
    mask = 16'hFFFF >> (16 - bits);
    low_ones = ((value & mask) == mask);
  endfunction : low_ones

endpackage : clock_gen_pkg

// File: design/clock_generator.sv
/*
  Clock generator with prescalers. Clocks are carried as one-cycle tick enables on clock_in.
  Assumes main and sub oscillator ticks arrive synchronous to clock_in and slower than half its rate,
  and that the power-save modes and control bits come from the surrounding controller.
*/
// How it works
// - The main oscillator halts in stop mode, or when the stop bit is set while the cpu runs from the subclock.
// - The system clock selector offers fxx, fxx/2, /4, /8, /16, /32 or the subclock.
// - A cpu-side prescaler divides fxx down to /32 and feeds these to the selector.
// - The selected system clock drives the core memories and can be sent out on the clock output pin.
// - A peripheral prescaler provides fxx down to fxx/1024 to the peripherals.
// - A watch prescaler divides the raw oscillator clock down to 32.768 kHz for the watch timer.
// - The pll multiplies the oscillator rate by four in pll mode.
// - The pll select bit chooses clock-through (oscillator as is) or the multiplied clock.
// - The pll run bit starts the pll when set and stops it when cleared.
// - The divider field codes 0000../1, 0001 /2 .. 0101 /32, 011x prohibited, 1xxx subclock, reset 0011.
// - The read-only source status reads 0 on the main clock and 1 on the subclock.
// - The stop bit does not halt the oscillator until the cpu has moved over to the subclock.
`timescale 1ns/1ns
module clock_generator #(
  parameter int WATCH_DIV = clock_gen_pkg::WATCH_DIV_DEFAULT,
  parameter int PLL_CNT_W = clock_gen_pkg::PLL_CNT_W_DEFAULT
) (
  input wire logic clock_in,
  input wire logic reset_in,
  input wire logic clock_enable_in,
  input wire logic main_osc_tick_in,
  input wire logic sub_osc_tick_in,
  input wire logic stop_mode_in,
  input wire logic idle_mode_in,
  input wire logic halt_mode_in,
  input wire logic main_osc_stop_bit_in,
  input wire logic pll_output_select_bit_in,
  input wire logic pll_run_bit_in,
  input wire logic cpu_divider_write_in,
  input wire logic [clock_gen_pkg::CPU_DIV_W-1:0] cpu_divider_field_in,
  input wire logic clock_output_enable_in,
  output logic [clock_gen_pkg::CPU_DIV_W-1:0] cpu_divider_field_out,
  output logic cpu_source_status_bit_out,
  output logic main_osc_run_out,
  output logic pll_active_out,
  output logic system_tick_out,
  output logic cpu_tick_out,
  output logic [clock_gen_pkg::PERIPH_TAPS-1:0] periph_tick_out,
  output logic watch_tick_out,
  output logic clock_output_pin_out
);
  import clock_gen_pkg::*;

  // refuse ratios and counter widths the logic cannot serve
  if (WATCH_DIV < 2 || WATCH_DIV > 65535 || PLL_CNT_W < 4 || PLL_CNT_W > 32) begin : g_bad_size
    $error("clock_generator: unsupported WATCH_DIV or PLL_CNT_W");
  end

  ////////////////////////////////////////////////////////////////////////////
  // control state
  logic [CPU_DIV_W-1:0] div_q, div_d;
  src_state_e src_q, src_d;
  logic osc_run_q, osc_run_d;
  logic pll_run_q, pll_run_d;

  logic fx_tick;
  logic fxx_tick;
  logic pll_tick;
  logic [CPU_TAPS-1:0] cpu_taps;
  logic [PERIPH_TAPS-1:0] periph_taps;
  logic watch_wrap;
  logic main_sel_tick;
  logic sel_tick;
  logic sys_gate;

  // raw oscillator only counts while it runs
  assign fx_tick = main_osc_tick_in && osc_run_q;

  ////////////////////////////////////////////////////////////////////////////
  // divider field, source switch, oscillator and pll run
  always_comb begin
    div_d = div_q;
    if (cpu_divider_write_in && !div_prohibited(cpu_divider_field_in)) begin
      div_d = cpu_divider_field_in;
    end
    src_d = src_q;
    unique case (src_q)
      SRC_MAIN: begin
        if (div_q[CPU_DIV_SUB_POS]) begin
          src_d = SRC_TO_SUB;
        end
      end
      SRC_TO_SUB: begin
        if (!div_q[CPU_DIV_SUB_POS]) begin
          src_d = SRC_MAIN;
        end else if (sub_osc_tick_in) begin
          src_d = SRC_SUB;
        end
      end
      SRC_SUB: begin
        if (!div_q[CPU_DIV_SUB_POS]) begin
          src_d = SRC_TO_MAIN;
        end
      end
      SRC_TO_MAIN: begin
        if (div_q[CPU_DIV_SUB_POS]) begin
          src_d = SRC_SUB;
        end else if (main_sel_tick) begin
          src_d = SRC_MAIN;
        end
      end
    endcase
    // stop bit only counts once the cpu is on the subclock
    osc_run_d = !(stop_mode_in || (main_osc_stop_bit_in && cpu_source_status_bit_out));
    pll_run_d = pll_run_bit_in;
  end

  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      div_q <= CPU_DIV_RESET;
      src_q <= SRC_MAIN;
      osc_run_q <= 1'b1;
      pll_run_q <= 1'b0;
    end else if (clock_enable_in) begin
      div_q <= div_d;
      src_q <= src_d;
      osc_run_q <= osc_run_d;
      pll_run_q <= pll_run_d;
    end
  end

  // status follows the clock actually in use
  assign cpu_source_status_bit_out = (src_q == SRC_SUB) || (src_q == SRC_TO_MAIN);
  assign cpu_divider_field_out = div_q;
  assign main_osc_run_out = osc_run_q;
  assign pll_active_out = pll_run_q;

  ////////////////////////////////////////////////////////////////////////////
  // pll: measure the oscillator period, emit four evenly spaced ticks
  logic [PLL_CNT_W-1:0] per_cnt_q, per_cnt_d;
  logic [PLL_CNT_W-1:0] quarter_q, quarter_d;
  logic [PLL_CNT_W-1:0] phase_q, phase_d;
  logic [1:0] emitted_q, emitted_d;

  always_comb begin
    per_cnt_d = per_cnt_q + PLL_CNT_W'(1);
    quarter_d = quarter_q;
    phase_d = phase_q + PLL_CNT_W'(1);
    emitted_d = emitted_q;
    pll_tick = 1'b0;
    if (!pll_run_q) begin
      per_cnt_d = '0;
      quarter_d = '0;
      phase_d = '0;
      emitted_d = '0;
    end else if (fx_tick) begin
      // period / 4 gives the x4 spacing
      quarter_d = (per_cnt_q + PLL_CNT_W'(1)) >> 2;
      per_cnt_d = '0;
      phase_d = '0;
      emitted_d = '0;
      pll_tick = (quarter_q != '0);
    end else if (quarter_q != '0 && emitted_q != 2'(PLL_MULT - 1)
                 && phase_q + PLL_CNT_W'(1) >= quarter_q) begin
      phase_d = '0;
      emitted_d = emitted_q + 2'h1;
      pll_tick = 1'b1;
    end
  end

  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      per_cnt_q <= '0;
      quarter_q <= '0;
      phase_q <= '0;
      emitted_q <= '0;
    end else if (clock_enable_in) begin
      per_cnt_q <= per_cnt_d;
      quarter_q <= quarter_d;
      phase_q <= phase_d;
      emitted_q <= emitted_d;
    end
  end

  // clock-through passes fx, pll mode passes the multiplied ticks
  assign fxx_tick = pll_output_select_bit_in ? pll_tick : fx_tick;

  ////////////////////////////////////////////////////////////////////////////
  // prescalers
  tick_divider #(.TAPS(CPU_TAPS), .MODULO(CPU_MODULO)) cpu_prescaler (
    .clock_in(clock_in),
    .reset_in(reset_in),
    .enable_in(clock_enable_in),
    .tick_in(fxx_tick),
    .taps_out(cpu_taps),
    .wrap_out()
  );

  tick_divider #(.TAPS(PERIPH_TAPS), .MODULO(PERIPH_MODULO)) periph_prescaler (
    .clock_in(clock_in),
    .reset_in(reset_in),
    .enable_in(clock_enable_in),
    .tick_in(fxx_tick),
    .taps_out(periph_taps),
    .wrap_out()
  );

  tick_divider #(.TAPS(1), .MODULO(WATCH_DIV)) watch_prescaler (
    .clock_in(clock_in),
    .reset_in(reset_in),
    .enable_in(clock_enable_in),
    .tick_in(fx_tick),
    .taps_out(),
    .wrap_out(watch_wrap)
  );

  ////////////////////////////////////////////////////////////////////////////
  // system clock selector and gating
  always_comb begin
    main_sel_tick = cpu_taps[div_q[2:0] > 3'h5 ? 3'h5 : div_q[2:0]];
    if (src_q == SRC_SUB || src_q == SRC_TO_MAIN) begin
      sel_tick = sub_osc_tick_in;
    end else begin
      sel_tick = main_sel_tick;
    end
    sys_gate = !(idle_mode_in || stop_mode_in);
  end

  logic sys_tick_q, sys_tick_d;
  logic cpu_tick_q, cpu_tick_d;
  logic [PERIPH_TAPS-1:0] periph_q, periph_d;
  logic watch_q, watch_d;
  logic clk_pin_q, clk_pin_d;

  // registered tick outputs and clock pin level
  always_comb begin
    sys_tick_d = sel_tick && sys_gate;
    cpu_tick_d = sel_tick && sys_gate && !halt_mode_in;
    periph_d = sys_gate ? periph_taps : '0;
    watch_d = watch_wrap;
    clk_pin_d = clk_pin_q;
    if (!clock_output_enable_in) begin
      clk_pin_d = 1'b0;
    end else if (sys_tick_d) begin
      clk_pin_d = !clk_pin_q;
    end
  end

  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      sys_tick_q <= 1'b0;
      cpu_tick_q <= 1'b0;
      periph_q <= '0;
      watch_q <= 1'b0;
      clk_pin_q <= 1'b0;
    end else if (clock_enable_in) begin
      sys_tick_q <= sys_tick_d;
      cpu_tick_q <= cpu_tick_d;
      periph_q <= periph_d;
      watch_q <= watch_d;
      clk_pin_q <= clk_pin_d;
    end
  end

  assign system_tick_out = sys_tick_q;
  assign cpu_tick_out = cpu_tick_q;
  assign periph_tick_out = periph_q;
  assign watch_tick_out = watch_q;
  assign clock_output_pin_out = clk_pin_q;

endmodule : clock_generator

// File: design/tick_divider.sv
/*
  Ripple-free tick divider: counts input ticks modulo MODULO and offers one tick per power-of-two tap.
  Assumes the input tick is a one-cycle enable synchronous to clock_in.
*/
`timescale 1ns/1ns
module tick_divider #(
  parameter int TAPS = 6,
  parameter int MODULO = 32
) (
  input wire logic clock_in,
  input wire logic reset_in,
  input wire logic enable_in,
  input wire logic tick_in,
  output logic [TAPS-1:0] taps_out,
  output logic wrap_out
);
  import clock_gen_pkg::*;

  localparam int W = (MODULO > 2) ? $clog2(MODULO) : 1;

  // refuse sizes the counter and tap decode cannot serve
  if (MODULO < 2 || W > 16 || TAPS < 1 || TAPS - 1 > W) begin : g_bad_size
    $error("tick_divider: unsupported TAPS/MODULO");
  end

  logic [W-1:0] count_q;
  logic [W-1:0] count_d;

  ////////////////////////////////////////////////////////////////////////////
  // next count, wraps at MODULO-1
  always_comb begin
    count_d = count_q;
    if (tick_in) begin
      count_d = wrap_out ? '0 : count_q + W'(1);
    end
  end

  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      count_q <= '0;
    end else if (enable_in) begin
      count_q <= count_d;
    end
  end

  // tap k fires once every 2**k input ticks
  always_comb begin
    for (int k = 0; k < TAPS; k++) begin
      taps_out[k] = tick_in && (k == 0 || low_ones(16'(count_q), k));
    end
    wrap_out = tick_in && (count_q == W'(MODULO - 1));
  end

endmodule : tick_divider

// File: testbench/clock_generator_chk.sv
/*
  Port-level assertions for the clock generator.
  Assumes it is bound by port name onto clock_generator.
*/
`timescale 1ns/1ns
module clock_generator_chk (
  input wire logic clock_in,
  input wire logic reset_in,
  input wire logic clock_enable_in,
  input wire logic stop_mode_in,
  input wire logic idle_mode_in,
  input wire logic halt_mode_in,
  input wire logic main_osc_stop_bit_in,
  input wire logic cpu_divider_write_in,
  input wire logic [clock_gen_pkg::CPU_DIV_W-1:0] cpu_divider_field_in,
  input wire logic [clock_gen_pkg::CPU_DIV_W-1:0] cpu_divider_field_out,
  input wire logic cpu_source_status_bit_out,
  input wire logic main_osc_run_out,
  input wire logic pll_active_out,
  input wire logic system_tick_out,
  input wire logic cpu_tick_out,
  input wire logic [clock_gen_pkg::PERIPH_TAPS-1:0] periph_tick_out
);
  import clock_gen_pkg::*;
  logic take;
  logic stop_req;
  // accepted divider write and oscillator stop request
  assign take = clock_enable_in & cpu_divider_write_in & (cpu_divider_field_in[3:1] != 3'h3);
  assign stop_req = stop_mode_in | (main_osc_stop_bit_in & cpu_source_status_bit_out);
  default clocking @(posedge clock_in); endclocking
  default disable iff (reset_in);
  ////////////////////////////////////////
  a_reset_vals: assert property ($fell(reset_in) |-> cpu_divider_field_out == CPU_DIV_RESET
    && !cpu_source_status_bit_out && main_osc_run_out && !pll_active_out) else $error("bad reset values");
  a_osc_stop: assert property (clock_enable_in |=> main_osc_run_out == !$past(stop_req))
    else $error("oscillator run wrong");
  a_div_take: assert property (take |=> cpu_divider_field_out == $past(cpu_divider_field_in))
    else $error("divider write lost");
  a_div_hold: assert property (!take |=> $stable(cpu_divider_field_out))
    else $error("divider changed unasked");
  a_idle_gate: assert property (clock_enable_in && (idle_mode_in || stop_mode_in) |=>
    !system_tick_out && !cpu_tick_out && !(|periph_tick_out)) else $error("tick in idle or stop");
  a_halt_gate: assert property (clock_enable_in && halt_mode_in |=> !cpu_tick_out)
    else $error("cpu tick in halt");
  a_cpu_in_sys: assert property (cpu_tick_out |-> system_tick_out)
    else $error("cpu tick without system tick");
  a_tap_nest: assert property (periph_tick_out[5] |-> &periph_tick_out[5:0])
    else $error("tap order wrong");
  a_tap_top: assert property (periph_tick_out[PERIPH_TAPS-1] |-> &periph_tick_out)
    else $error("top tap without lower taps");
  a_status_src: assert property ($changed(cpu_source_status_bit_out) |->
    cpu_source_status_bit_out == cpu_divider_field_out[CPU_DIV_SUB_POS]) else $error("status wrong");
endmodule : clock_generator_chk

bind clock_generator clock_generator_chk chk (.*);

// File: testbench/osc_load_model.sv
/*
  Far side: main and sub oscillators, and the clock loads that count ticks.
  Assumes it shares clock_in with the generator.
*/
`timescale 1ns/1ns
module osc_load_model #(
  parameter int MAIN_P = 8,
  parameter int SUB_P = 64
) (
  input wire logic clock_in,
  input wire logic clear_in,
  input wire logic main_run_in,
  input wire logic sys_in,
  input wire logic cpu_in,
  input wire logic per_in,
  input wire logic watch_in,
  input wire logic pin_in,
  output logic main_tick_out,
  output logic sub_tick_out
);
  int mc = 0, sc = 0, sys_n = 0, cpu_n = 0, per_n = 0, wat_n = 0, pin_n = 0;
  logic mt = 0, st = 0, pin_last = 0;
  assign main_tick_out = mt;
  assign sub_tick_out = st;
  // oscillators, main one silent while stopped
  always @(posedge clock_in) begin
    mc <= (mc + 1) % MAIN_P;
    sc <= (sc + 1) % SUB_P;
    mt <= main_run_in && mc == 0;
    st <= sc == 0;
  end
  // loads count received ticks and pin toggles
  always @(posedge clock_in) begin
    pin_last <= pin_in;
    sys_n <= clear_in ? 0 : sys_n + sys_in;
    cpu_n <= clear_in ? 0 : cpu_n + cpu_in;
    per_n <= clear_in ? 0 : per_n + per_in;
    wat_n <= clear_in ? 0 : wat_n + watch_in;
    pin_n <= clear_in ? 0 : pin_n + (pin_in != pin_last);
  end
endmodule : osc_load_model

// File: testbench/test_clock_generator.sv
/*
  Self-checking bench for clock_generator with oscillator and load model.
  Assumes checker and model are compiled first; fx period 8 cycles, subclock 64.
*/
`timescale 1ns/1ns
module test_clock_generator;
  import clock_gen_pkg::*;
  logic clock_in = 0, reset_in = 1, clock_enable_in = 1, main_osc_tick_in, sub_osc_tick_in;
  logic stop_mode_in = 0, idle_mode_in = 0, halt_mode_in = 0, main_osc_stop_bit_in = 0;
  logic pll_output_select_bit_in = 0, pll_run_bit_in = 0, cpu_divider_write_in = 0, clock_output_enable_in = 1;
  logic [CPU_DIV_W-1:0] cpu_divider_field_in = 4'h0, cpu_divider_field_out;
  logic cpu_source_status_bit_out, main_osc_run_out, pll_active_out, system_tick_out, cpu_tick_out;
  logic watch_tick_out, clock_output_pin_out, clear = 0;
  logic [PERIPH_TAPS-1:0] periph_tick_out;
  int errors = 0, checked = 0, cycles = 0;
  clock_generator #(.WATCH_DIV(4)) dut (.*);
  osc_load_model load (.clock_in, .clear_in(clear), .main_run_in(main_osc_run_out), .sys_in(system_tick_out),
    .cpu_in(cpu_tick_out), .per_in(periph_tick_out[4]), .watch_in(watch_tick_out),
    .pin_in(clock_output_pin_out), .main_tick_out(main_osc_tick_in), .sub_tick_out(sub_osc_tick_in));
  ////////////////////////////////////////
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH at %0t: saw %0d, expected %0d", $time, seen, exp);
    end
  endtask : check
  task automatic set_div(input logic [3:0] code);
    @(posedge clock_in);
    cpu_divider_write_in <= 1;
    cpu_divider_field_in <= code;
    @(posedge clock_in);
    cpu_divider_write_in <= 0;
  endtask : set_div
  // clear the load counters, then count 512 cycles
  task automatic window();
    @(posedge clock_in) clear <= 1;
    @(posedge clock_in) clear <= 0;
    repeat (512) @(posedge clock_in);
    #1;
  endtask : window
  task automatic wait_status(input logic v);
    for (int i = 0; i < 400 && cpu_source_status_bit_out !== v; i++) @(posedge clock_in);
    #1;
    check(cpu_source_status_bit_out, v);
  endtask : wait_status
  task automatic test_reset();
    #1;
    check(cpu_divider_field_out, 4'h3);
    check(cpu_source_status_bit_out, 1'b0);
    check(main_osc_run_out, 1'b1);
    check(pll_active_out, 1'b0);
    $display("done: reset");
  endtask : test_reset
  task automatic test_ratios();
    for (int k = 0; k < CPU_TAPS; k++) begin
      set_div(4'(k));
      repeat (300) @(posedge clock_in);
      window();
      check(load.sys_n, 16'(64 >> k));
      check(load.cpu_n, 16'(64 >> k));
      check(load.pin_n, 16'(64 >> k));
      check(load.per_n, 16'h4);
      check(load.wat_n, 16'h10);
    end
    $display("done: ratios");
  endtask : test_ratios
  task automatic test_refuse();
    set_div(4'h6);
    set_div(4'h7);
    @(posedge clock_in) clock_enable_in <= 0;
    set_div(4'h1);
    @(posedge clock_in) clock_enable_in <= 1;
    #1;
    check(cpu_divider_field_out, 4'h5);
    $display("done: refused writes");
  endtask : test_refuse
  task automatic test_pll();
    set_div(4'h0);
    pll_run_bit_in <= 1;
    pll_output_select_bit_in <= 1;
    repeat (300) @(posedge clock_in);
    window();
    check(pll_active_out, 1'b1);
    check(load.sys_n, 16'h100);
    check(load.per_n, 16'h10);
    check(load.wat_n, 16'h10);
    @(posedge clock_in) pll_run_bit_in <= 0;
    window();
    check(pll_active_out, 1'b0);
    check(load.sys_n, 16'h0);
    @(posedge clock_in) pll_output_select_bit_in <= 0;
    window();
    check(load.sys_n, 16'h40);
    $display("done: pll");
  endtask : test_pll
  task automatic test_sub();
    @(posedge clock_in) main_osc_stop_bit_in <= 1;
    repeat (20) @(posedge clock_in);
    #1;
    check(main_osc_run_out, 1'b1);
    set_div(4'h8);
    wait_status(1'b1);
    repeat (3) @(posedge clock_in);
    #1;
    check(main_osc_run_out, 1'b0);
    window();
    check(load.sys_n, 16'h8);
    check(load.per_n, 16'h0);
    @(posedge clock_in) main_osc_stop_bit_in <= 0;
    set_div(4'h0);
    wait_status(1'b0);
    $display("done: subclock");
  endtask : test_sub
  task automatic test_modes();
    @(posedge clock_in) idle_mode_in <= 1;
    window();
    check(load.sys_n, 16'h0);
    check(load.per_n, 16'h0);
    check(load.wat_n, 16'h10);
    @(posedge clock_in) idle_mode_in <= 0;
    halt_mode_in <= 1;
    clock_output_enable_in <= 0;
    window();
    check(load.cpu_n, 16'h0);
    check(load.sys_n, 16'h40);
    check(load.pin_n, 16'h0);
    check(clock_output_pin_out, 1'b0);
    @(posedge clock_in) halt_mode_in <= 0;
    clock_output_enable_in <= 1;
    stop_mode_in <= 1;
    window();
    check(main_osc_run_out, 1'b0);
    check(load.sys_n, 16'h0);
    @(posedge clock_in) stop_mode_in <= 0;
    $display("done: power modes");
  endtask : test_modes
  task automatic close_out();
    $display("comparisons %0d, mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : close_out
  ////////////////////////////////////////
  // clock and hang guard
  initial forever #5 clock_in = ~clock_in;
  always @(posedge clock_in) begin
    cycles++;
    if (cycles == 30000) begin
      errors++;
      close_out();
    end
  end
  // main sequence
  initial begin
    repeat (3) @(posedge clock_in);
    reset_in <= 0;
    test_reset();
    test_ratios();
    test_refuse();
    test_pll();
    test_sub();
    test_modes();
    close_out();
  end
endmodule : test_clock_generator
